// ### irq_fifo_ctrl.sv
// Interrupt mask, prioritised interrupt source and queue control for one channel
`timescale 1ns/1ps
module irq_fifo_ctrl #(
  parameter int LEVEL_W = 7
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clk_en,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Channel status
  input wire irq_fifo_pkg::chan_evt_t evt,
  input wire logic [3:0] handshake_change,
  input wire logic immediate_error,
  input wire logic enhanced_enable,
  input wire logic half_duplex,
  input wire logic table_dir,
  input wire logic [1:0] table_sel,
  input wire logic [LEVEL_W-1:0] rx_level,
  input wire logic [LEVEL_W-1:0] tx_level,
  input wire logic holding_empty,
  input wire logic xmit_empty,
  // Controls out
  output logic fifo_enable,
  output logic sleep_enable,
  output logic rx_fifo_reset,
  output logic tx_fifo_reset,
  output logic irq
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0] mask_q;
  logic [7:0] qctrl_q;
  logic [5:0] rx_trig_q;
  logic [5:0] tx_trig_q;
  logic line_q, tout_q, tx_q, modem_q, xoff_q, wake_q;
  logic [5:0] tout_cnt_q;
  logic tx_above_q;
  logic [5:0] code;
  logic [7:0] rdata_d;
  logic src_rd, mask_wr, q_wr, trig_wr;
  logic rx_hit, tx_hit, tx_cond, tx_cond_q;

  assign src_rd = clk_en && reg_rd && reg_addr == irq_fifo_pkg::ADDR_SOURCE;
  assign mask_wr = clk_en && reg_wr && reg_addr == irq_fifo_pkg::ADDR_MASK;
  assign q_wr = clk_en && reg_wr && reg_addr == irq_fifo_pkg::ADDR_QCTRL;
  assign trig_wr = clk_en && reg_wr && reg_addr == irq_fifo_pkg::ADDR_TRIG;

  // Receive trigger from shared table
  function automatic logic [5:0] rx_trig(input logic [1:0] t, input logic [1:0] c,
                                         input logic [5:0] prog);
    logic [5:0] v;
    v = 6'h01;
    case (t)
      2'b00: v = (c == 2'b00) ? 6'h01 : (c == 2'b01) ? 6'h04 : (c == 2'b10) ? 6'h08 : 6'h0E;
      2'b01: v = (c == 2'b00) ? 6'h08 : (c == 2'b01) ? 6'h10 : (c == 2'b10) ? 6'h18 : 6'h1C;
      2'b10: v = (c == 2'b00) ? 6'h08 : (c == 2'b01) ? 6'h10 : (c == 2'b10) ? 6'h38 : 6'h3C;
      default: v = prog;
    endcase
    return v;
  endfunction

  // Transmit trigger from shared table
  function automatic logic [5:0] tx_trig(input logic [1:0] t, input logic [1:0] c,
                                         input logic [5:0] prog);
    logic [5:0] v;
    v = 6'h01;
    case (t)
      2'b00: v = 6'h01;
      2'b01: v = (c == 2'b00) ? 6'h10 : (c == 2'b01) ? 6'h08 : (c == 2'b10) ? 6'h18 : 6'h1E;
      2'b10: v = (c == 2'b00) ? 6'h08 : (c == 2'b01) ? 6'h10 : (c == 2'b10) ? 6'h20 : 6'h38;
      default: v = prog;
    endcase
    return v;
  endfunction

  // ---------------------------------------------------------------
  // Mask register
  // ---------------------------------------------------------------
  // Sleep and Xoff bits only move with enhanced functions on
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
      mask_q <= irq_fifo_pkg::MASK_RESET;
    else if (mask_wr)
    begin
      mask_q[3:0] <= reg_wdata[3:0];
      if (enhanced_enable)
        mask_q[5:4] <= reg_wdata[5:4];
    end

  // ---------------------------------------------------------------
  // Queue control and trigger registers
  // ---------------------------------------------------------------
  // Bit 0 clear disables FIFOs and ignores the rest
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
      qctrl_q <= irq_fifo_pkg::QCTRL_RESET;
    else if (q_wr)
    begin
      qctrl_q[irq_fifo_pkg::Q_EN] <= reg_wdata[irq_fifo_pkg::Q_EN];
      if (reg_wdata[irq_fifo_pkg::Q_EN])
      begin
        qctrl_q[7:6] <= reg_wdata[7:6];
        if (enhanced_enable)
          qctrl_q[5:4] <= reg_wdata[5:4];
      end
    end

  // FIFO reset strobes: one cycle, never stored
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      rx_fifo_reset <= 1'b0;
      tx_fifo_reset <= 1'b0;
    end
    else if (clk_en)
    begin
      rx_fifo_reset <= q_wr && reg_wdata[irq_fifo_pkg::Q_EN]
        && reg_wdata[irq_fifo_pkg::Q_RXRST];
      tx_fifo_reset <= q_wr && reg_wdata[irq_fifo_pkg::Q_EN]
        && reg_wdata[irq_fifo_pkg::Q_TXRST];
    end

  // Programmable level goes to receive or transmit side
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      rx_trig_q <= irq_fifo_pkg::TRIG_RESET;
      tx_trig_q <= irq_fifo_pkg::TRIG_RESET;
    end
    else if (trig_wr)
    begin
      if (table_dir)
        tx_trig_q <= reg_wdata[5:0];
      else
        rx_trig_q <= reg_wdata[5:0];
    end

  assign fifo_enable = qctrl_q[irq_fifo_pkg::Q_EN];
  assign sleep_enable = mask_q[irq_fifo_pkg::MASK_SLEEP];

  // ---------------------------------------------------------------
  // Level conditions
  // ---------------------------------------------------------------
  // Both sides read one table select, so the last choice applies to both
  assign rx_hit = fifo_enable
    ? (rx_level >= LEVEL_W'(rx_trig(table_sel, qctrl_q[7:6], rx_trig_q)))
    : (rx_level != '0);
  // Empty counts only when the reload never went above the trigger
  assign tx_hit = half_duplex ? xmit_empty
    : !fifo_enable ? holding_empty
    : (tx_level < LEVEL_W'(tx_trig(table_sel, qctrl_q[5:4], tx_trig_q)) && tx_above_q)
      || (tx_level == '0 && !tx_above_q);
  assign tx_cond = tx_hit && mask_q[irq_fifo_pkg::MASK_TX];

  // Track whether the last reload passed the trigger
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      tx_above_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (tx_level > LEVEL_W'(tx_trig(table_sel, qctrl_q[5:4], tx_trig_q)))
        tx_above_q <= 1'b1;
      else if (tx_level == '0)
        tx_above_q <= 1'b0;
    end

  // ---------------------------------------------------------------
  // Sticky sources
  // ---------------------------------------------------------------
  // Line status: overrun at once, others per immediate bit
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
      line_q <= 1'b0;
    else if (clk_en)
    begin
      if (evt.rx_overrun || (immediate_error ? evt.rx_err_arrive : evt.rx_err_read))
        line_q <= 1'b1;
      else if (evt.line_read)
        line_q <= 1'b0;
    end

  // Timeout counter: restarts on each arrival or read
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      tout_cnt_q <= '0;
      tout_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (rx_level == '0 || evt.rx_char || evt.holding_read)
        tout_cnt_q <= '0;
      else if (evt.bit_tick && tout_cnt_q != 6'(irq_fifo_pkg::TOUT_BITS))
        tout_cnt_q <= tout_cnt_q + 6'h01;
      if (evt.bit_tick && rx_level != '0 && tout_cnt_q == 6'(irq_fifo_pkg::TOUT_BITS - 1))
        tout_q <= 1'b1;
      else if (evt.holding_read)
        tout_q <= 1'b0;
    end

  // Transmit-ready: set on rising condition or enable, cleared by read or write
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      tx_q <= 1'b0;
      tx_cond_q <= 1'b0;
    end
    else if (clk_en)
    begin
      tx_cond_q <= tx_cond;
      if (tx_cond && !tx_cond_q)
        tx_q <= 1'b1;
      else if (src_rd && code == irq_fifo_pkg::CODE_TRANSMIT_READY_EVENT || evt.holding_write)
        tx_q <= 1'b0;
      else if (!tx_cond)
        tx_q <= 1'b0;
    end

  // Modem, Xoff and wake-up flags
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      modem_q <= 1'b0;
      xoff_q <= 1'b0;
      wake_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (|handshake_change)
        modem_q <= 1'b1;
      else if (evt.modem_read)
        modem_q <= 1'b0;
      if (evt.xoff_match && mask_q[irq_fifo_pkg::MASK_XOFF])
        xoff_q <= 1'b1;
      else if (evt.xon_match || (src_rd && code == irq_fifo_pkg::CODE_XOFF))
        xoff_q <= 1'b0;
      if (evt.sleep_exit)
        wake_q <= 1'b1;
      else if (src_rd)
        wake_q <= 1'b0;
    end

  // ---------------------------------------------------------------
  // Priority encoder and read data
  // ---------------------------------------------------------------
  // Only the top pending source is shown; lower ones stay queued
  always_comb
  begin
    if (line_q && mask_q[irq_fifo_pkg::MASK_LINE])
      code = irq_fifo_pkg::CODE_LINE;
    else if (tout_q && mask_q[irq_fifo_pkg::MASK_RX])
      code = irq_fifo_pkg::CODE_TOUT;
    else if (rx_hit && mask_q[irq_fifo_pkg::MASK_RX])
      code = irq_fifo_pkg::CODE_RECEIVE_READY_EVENT;
    else if (tx_q)
      code = irq_fifo_pkg::CODE_TRANSMIT_READY_EVENT;
    else if (modem_q && mask_q[irq_fifo_pkg::MASK_MODEM])
      code = irq_fifo_pkg::CODE_MODEM;
    else if (xoff_q)
      code = irq_fifo_pkg::CODE_XOFF;
    else
      code = irq_fifo_pkg::CODE_NONE;
  end

  always_comb
  begin
    rdata_d = 8'h00;
    case (reg_addr)
      irq_fifo_pkg::ADDR_MASK: rdata_d = mask_q;
      irq_fifo_pkg::ADDR_SOURCE: rdata_d = {{2{fifo_enable}}, 1'b0, code[4:0]};
      default: rdata_d = 8'h00;
    endcase
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
      reg_rdata <= 8'h00;
    else if (clk_en)
      reg_rdata <= reg_rd ? rdata_d : 8'h00;

  // Interrupt pin from the encoder plus wake-up, which reads as no source
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
      irq <= 1'b0;
    else if (clk_en)
      irq <= (code != irq_fifo_pkg::CODE_NONE) || wake_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_irq_follows_code: assert property (@(posedge mclk) disable iff (!resetn)
    clk_en |=> irq == (($past(code) != irq_fifo_pkg::CODE_NONE) || $past(wake_q)))
    else $error("irq does not follow pending code");
  chk_fifo_status_bits: assert property (@(posedge mclk) disable iff (!resetn)
    clk_en && reg_rd && reg_addr == irq_fifo_pkg::ADDR_SOURCE
      |=> reg_rdata[7:5] == {{2{$past(fifo_enable)}}, 1'b0})
    else $error("status bits 7:5 wrong");
  chk_reset_pulse: assert property (@(posedge mclk) disable iff (!resetn)
    rx_fifo_reset && clk_en |=> !rx_fifo_reset || $past(q_wr))
    else $error("fifo reset did not self clear");
  chk_mask_guard: assert property (@(posedge mclk) disable iff (!resetn)
    mask_wr && !enhanced_enable |=> $stable(mask_q[5:4]))
    else $error("mask bits 5:4 written without enhanced enable");
  chk_qctrl_ignore: assert property (@(posedge mclk) disable iff (!resetn)
    q_wr && !reg_wdata[irq_fifo_pkg::Q_EN] |=> $stable(qctrl_q[7:4]) && !fifo_enable)
    else $error("queue control bits taken without enable");
  chk_line_first: assert property (@(posedge mclk) disable iff (!resetn)
    line_q && mask_q[irq_fifo_pkg::MASK_LINE] |-> code == irq_fifo_pkg::CODE_LINE)
    else $error("line status not top priority");
  chk_wake_clear: assert property (@(posedge mclk) disable iff (!resetn)
    src_rd && !evt.sleep_exit |=> !wake_q)
    else $error("wake flag not cleared by status read");
  chk_tx_clear: assert property (@(posedge mclk) disable iff (!resetn)
    clk_en && evt.holding_write && !(tx_cond && !tx_cond_q) |=> !tx_q)
    else $error("transmit ready not cleared by holding write");
  chk_line_set: assert property (@(posedge mclk) disable iff (!resetn)
    clk_en && evt.rx_overrun |=> line_q)
    else $error("overrun did not set line flag");
endmodule // irq_fifo_ctrl

// ### irq_fifo_pkg.sv
// Package with register map, field layout, priority codes and event type for the interrupt block
//
// Functional notes
// - Transmit-ready interrupt on holding empty or FIFO below trigger, when enabled.
// - Enabling transmit-ready while holding already empty raises the interrupt at once.
// - Line-status enable raises interrupt while any of line bits 1 to 4 set.
// - Overrun interrupts at once; other errors on read-out unless immediate bit set.
// - Mask bit 3 gates modem; bits 4,5 writable only with enhanced enable.
// - Status read shows only highest pending source; others stay queued.
// - Priority codes: 06,0C,04,02,00,10 and 01 for none or wake-up.
// - Status bit 0 low while pending, high when idle or just woken.
// - Status bits 7:6 mirror FIFO enable; bit 5 reads zero.
// - Receive timeout after four characters plus twelve bits with data present.
// - Transmit-ready uses trigger or empty; full transmitter empty in half-duplex.
// - Modem interrupt on modem bits 0 to 3; Xoff match sets status bit 4.
// - Leaving sleep posts wake-up indication, cleared by a status read.
// - Clear line on line read, ready below trigger, timeout on holding read, modem read.
// - Transmit-ready cleared by status read or holding write.
// - Xoff interrupt cleared by status read or Xon reception.
// - Queue control write-only; other bits ignored unless bit 0 written one.
// - FIFO reset bits pulse pointer reset once and self-clear.
// - Transmit interrupt below trigger, or at empty if last reload not above.
// - Receive interrupt at trigger crossing; one shared table, last selection wins.
// - Table 00 receive 1,4,8,14 transmit 1; table 01 receive 8,16,24,28 transmit 16,8,24,30.
// - Table 10 receive 8,16,56,60 transmit 8,16,32,56; table 11 programmable.
package irq_fifo_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [2:0] ADDR_MASK = 3'h1;
  localparam logic [2:0] ADDR_SOURCE = 3'h2;
  localparam logic [2:0] ADDR_QCTRL = 3'h2;
  localparam logic [2:0] ADDR_TRIG = 3'h3;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] QCTRL_RESET = 8'h00;
  localparam logic [5:0] TRIG_RESET = 6'h01;
  // Field positions
  localparam int MASK_RX = 0;
  localparam int MASK_TX = 1;
  localparam int MASK_LINE = 2;
  localparam int MASK_MODEM = 3;
  localparam int MASK_SLEEP = 4;
  localparam int MASK_XOFF = 5;
  localparam int Q_EN = 0;
  localparam int Q_RXRST = 1;
  localparam int Q_TXRST = 2;
  // Priority codes for status bits 5:0
  localparam logic [5:0] CODE_LINE = 6'h06;
  localparam logic [5:0] CODE_TOUT = 6'h0C;
  localparam logic [5:0] CODE_RECEIVE_READY_EVENT = 6'h04;
  localparam logic [5:0] CODE_TRANSMIT_READY_EVENT = 6'h02;
  localparam logic [5:0] CODE_MODEM = 6'h00;
  localparam logic [5:0] CODE_XOFF = 6'h10;
  localparam logic [5:0] CODE_NONE = 6'h01;
  // Timeout: four characters plus twelve bits, in bit times
  localparam int CHAR_BITS = 10;
  localparam int TOUT_BITS = 4 * CHAR_BITS + 12;

  // Events from the rest of the channel
  typedef struct packed {
    logic rx_overrun;     // Overrun on arrival
    logic rx_err_read;    // Errored char read out of FIFO
    logic rx_err_arrive;  // Errored char arrived
    logic line_read;
    logic holding_read;
    logic modem_read;
    logic holding_write;
    logic xoff_match;
    logic xon_match;
    logic sleep_exit;
    logic bit_tick;       // One pulse per bit time
    logic rx_char;        // Character stored in receive FIFO
  } chan_evt_t;
endpackage

// ### chan_model.sv
// Behavioural model of the channel receive FIFO counter and bit timer
`timescale 1ns/1ps
module chan_model #(
  parameter int LEVEL_W = 7
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Requests from the bench and the block
  input wire logic rx_push,
  input wire logic rx_fifo_reset,
  // Channel state
  output logic [LEVEL_W-1:0] rx_level,
  output logic bit_tick
);
  // ---------------------------------------------------------------
  // Receive level
  // ---------------------------------------------------------------
  // Reset pulse wins over a push, since the pointers are cleared
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_level <= '0;
    end
    else
    begin
      rx_level <= rx_fifo_reset ? '0 : rx_level + LEVEL_W'(rx_push);
    end
  end

  // Tick every other cycle keeps the timeout short in simulation
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      bit_tick <= 1'b0;
    end
    else
    begin
      bit_tick <= !bit_tick;
    end
  end
endmodule // chan_model

// ### testbench.sv
// Self-checking testbench for the interrupt and queue control block
`timescale 1ns/1ps
module testbench;
  localparam int LW = 7;
  logic mclk;
  logic resetn;
  logic clk_en;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  irq_fifo_pkg::chan_evt_t evt;
  irq_fifo_pkg::chan_evt_t evt_w;
  logic [3:0] handshake_change;
  logic immediate_error;
  logic enhanced_enable;
  logic [LW-1:0] rx_level;
  logic holding_empty;
  logic half_duplex;
  logic xmit_empty;
  logic [1:0] table_sel;
  logic [LW-1:0] tx_level;
  logic rx_push;
  logic bit_tick;
  logic fifo_enable;
  logic sleep_enable;
  logic rx_fifo_reset;
  logic tx_fifo_reset;
  logic irq;
  int failures;
  int num_checks;

  // ---------------------------------------------------------------
  // Clock, design and channel model
  // ---------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Bit timer comes from the model, the other events from the bench
  always_comb
  begin
    evt_w = evt;
    evt_w.bit_tick = bit_tick;
  end

  irq_fifo_ctrl #(.LEVEL_W(LW)) dut (
    .mclk(mclk), .resetn(resetn), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .evt(evt_w), .handshake_change(handshake_change),
    .immediate_error(immediate_error), .enhanced_enable(enhanced_enable),
    .half_duplex(half_duplex), .table_dir(1'b0), .table_sel(table_sel), .rx_level(rx_level),
    .tx_level(tx_level), .holding_empty(holding_empty), .xmit_empty(xmit_empty),
    .fifo_enable(fifo_enable), .sleep_enable(sleep_enable),
    .rx_fifo_reset(rx_fifo_reset), .tx_fifo_reset(tx_fifo_reset), .irq(irq)
  );

  chan_model #(.LEVEL_W(LW)) far_end (
    .mclk(mclk), .resetn(resetn), .rx_push(rx_push), .rx_fifo_reset(rx_fifo_reset),
    .rx_level(rx_level), .bit_tick(bit_tick)
  );

  // ---------------------------------------------------------------
  // Access and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk(reg_rdata, exp);
    @(posedge mclk);
  endtask

  task automatic pulse(input irq_fifo_pkg::chan_evt_t e, input logic push);
    @(posedge mclk);
    evt <= e;
    rx_push <= push;
    @(posedge mclk);
    evt <= '0;
    rx_push <= 1'b0;
  endtask

  // Bounded wait, since the flags lag their cause by a cycle or two
  task automatic wait_irq(input logic exp);
    int n;
    n = 0;
    @(negedge mclk);
    while (irq !== exp && n < 300)
    begin
      @(negedge mclk);
      n++;
    end
    chk({7'h00, irq}, {7'h00, exp});
    @(posedge mclk);
  endtask

  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
    begin
      $display("No errors found");
    end
    else
    begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Whole run is about 300 cycles; allow fifty times that
  initial
  begin
    #75000;
    failures++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    tally_and_finish();
  end

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial
  begin
    failures = 0;
    num_checks = 0;
    resetn = 1'b0;
    clk_en = 1'b1;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    evt = '0;
    handshake_change = 4'h0;
    immediate_error = 1'b0;
    enhanced_enable = 1'b0;
    holding_empty = 1'b0;
    half_duplex = 1'b0;
    xmit_empty = 1'b1;
    table_sel = 2'h0;
    tx_level = 7'h00;
    rx_push = 1'b0;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    rd_chk(irq_fifo_pkg::ADDR_SOURCE, 8'h01);
    rd_chk(irq_fifo_pkg::ADDR_MASK, irq_fifo_pkg::MASK_RESET);
    // Frozen clock enable must drop the write
    clk_en <= 1'b0;
    wr(irq_fifo_pkg::ADDR_MASK, 8'h08);
    clk_en <= 1'b1;
    rd_chk(irq_fifo_pkg::ADDR_MASK, 8'h00);
    wr(irq_fifo_pkg::ADDR_MASK, 8'h30);
    rd_chk(irq_fifo_pkg::ADDR_MASK, 8'h00);
    enhanced_enable <= 1'b1;
    wr(irq_fifo_pkg::ADDR_MASK, 8'h30);
    rd_chk(irq_fifo_pkg::ADDR_MASK, 8'h30);
    chk({7'h00, sleep_enable}, 8'h01);
    // Xoff match, cleared by the status read
    pulse('{xoff_match: 1'b1, default: 1'b0}, 1'b0);
    wait_irq(1'b1);
    rd_chk(irq_fifo_pkg::ADDR_SOURCE, 8'h10);
    rd_chk(irq_fifo_pkg::ADDR_SOURCE, 8'h01);
    wait_irq(1'b0);
    // Wake-up raises the pin but reads as no source
    pulse('{sleep_exit: 1'b1, default: 1'b0}, 1'b0);
    wait_irq(1'b1);
    rd_chk(irq_fifo_pkg::ADDR_SOURCE, 8'h01);
    wait_irq(1'b0);
    // Transmit ready with the holding register already empty
    holding_empty <= 1'b1;
    wr(irq_fifo_pkg::ADDR_MASK, 8'h02);
    wait_irq(1'b1);
    rd_chk(irq_fifo_pkg::ADDR_SOURCE, 8'h02);
    wait_irq(1'b0);
    holding_empty <= 1'b0;
    @(posedge mclk);
    holding_empty <= 1'b1;
    wait_irq(1'b1);
    pulse('{holding_write: 1'b1, default: 1'b0}, 1'b0);
    wait_irq(1'b0);
    // Line and modem pending together: line first
    wr(irq_fifo_pkg::ADDR_MASK, 8'h0C);
    handshake_change <= 4'h2;
    pulse('{rx_overrun: 1'b1, default: 1'b0}, 1'b0);
    wait_irq(1'b1);
    rd_chk(irq_fifo_pkg::ADDR_SOURCE, 8'h06);
    pulse('{line_read: 1'b1, default: 1'b0}, 1'b0);
    rd_chk(irq_fifo_pkg::ADDR_SOURCE, 8'h00);
    handshake_change <= 4'h0;
    pulse('{modem_read: 1'b1, default: 1'b0}, 1'b0);
    rd_chk(irq_fifo_pkg::ADDR_SOURCE, 8'h01);
    wait_irq(1'b0);
    immediate_error <= 1'b1;
    pulse('{rx_err_arrive: 1'b1, default: 1'b0}, 1'b0);
    rd_chk(irq_fifo_pkg::ADDR_SOURCE, 8'h06);
    pulse('{line_read: 1'b1, default: 1'b0}, 1'b0);
    rd_chk(irq_fifo_pkg::ADDR_SOURCE, 8'h01);
    // Queue control: enable with both resets, then a refused write
    wr(irq_fifo_pkg::ADDR_QCTRL, 8'h07);
    @(negedge mclk);
    chk({5'h00, fifo_enable, rx_fifo_reset, tx_fifo_reset}, 8'h07);
    @(posedge mclk);
    @(negedge mclk);
    chk({5'h00, fifo_enable, rx_fifo_reset, tx_fifo_reset}, 8'h04);
    rd_chk(irq_fifo_pkg::ADDR_SOURCE, 8'hC1);
    wr(irq_fifo_pkg::ADDR_QCTRL, 8'h06);
    @(negedge mclk);
    chk({5'h00, fifo_enable, rx_fifo_reset, tx_fifo_reset}, 8'h00);
    // Receive trigger of four from the first table
    wr(irq_fifo_pkg::ADDR_QCTRL, 8'h41);
    wr(irq_fifo_pkg::ADDR_MASK, 8'h01);
    repeat (3) pulse('{rx_char: 1'b1, default: 1'b0}, 1'b1);
    rd_chk(irq_fifo_pkg::ADDR_SOURCE, 8'hC1);
    pulse('{rx_char: 1'b1, default: 1'b0}, 1'b1);
    wait_irq(1'b1);
    rd_chk(irq_fifo_pkg::ADDR_SOURCE, 8'hC4);
    wr(irq_fifo_pkg::ADDR_QCTRL, 8'h43);
    wait_irq(1'b0);
    // One character below trigger runs into the timeout
    pulse('{rx_char: 1'b1, default: 1'b0}, 1'b1);
    wait_irq(1'b1);
    rd_chk(irq_fifo_pkg::ADDR_SOURCE, 8'hCC);
    pulse('{holding_read: 1'b1, default: 1'b0}, 1'b0);
    rd_chk(irq_fifo_pkg::ADDR_SOURCE, 8'hC1);
    // Transmit trigger of sixteen from the second table, after a reload of twenty
    wr(irq_fifo_pkg::ADDR_QCTRL, 8'h47);
    table_sel <= 2'h1;
    tx_level <= 7'h14;
    wr(irq_fifo_pkg::ADDR_MASK, 8'h02);
    tx_level <= 7'h10;
    rd_chk(irq_fifo_pkg::ADDR_SOURCE, 8'hC1);
    tx_level <= 7'h0F;
    wait_irq(1'b1);
    rd_chk(irq_fifo_pkg::ADDR_SOURCE, 8'hC2);
    // Half-duplex ignores the level and waits for the transmitter
    half_duplex <= 1'b1;
    xmit_empty <= 1'b0;
    rd_chk(irq_fifo_pkg::ADDR_SOURCE, 8'hC1);
    xmit_empty <= 1'b1;
    wait_irq(1'b1);
    rd_chk(irq_fifo_pkg::ADDR_SOURCE, 8'hC2);
    // Reload below trigger only interrupts at empty
    half_duplex <= 1'b0;
    tx_level <= 7'h00;
    @(posedge mclk);
    tx_level <= 7'h0C;
    rd_chk(irq_fifo_pkg::ADDR_SOURCE, 8'hC1);
    tx_level <= 7'h00;
    wait_irq(1'b1);
    // Programmable receive level of two from the fourth table
    table_sel <= 2'h3;
    wr(irq_fifo_pkg::ADDR_MASK, 8'h01);
    wr(irq_fifo_pkg::ADDR_TRIG, 8'h02);
    pulse('{rx_char: 1'b1, default: 1'b0}, 1'b1);
    rd_chk(irq_fifo_pkg::ADDR_SOURCE, 8'hC1);
    pulse('{rx_char: 1'b1, default: 1'b0}, 1'b1);
    rd_chk(irq_fifo_pkg::ADDR_SOURCE, 8'hC4);
    tally_and_finish();
  end
endmodule // testbench
